// ==== tat_pkg.sv ====
// Package of register map, field layout and timing constants for the temperature alert block
package tat_pkg;
    // ------------------------------------------------------------
    // Register indices (byte address is four times the index)
    // ------------------------------------------------------------
    localparam logic [3:0] IDX_TEMPERATURE_RESULT = 4'h0;
    localparam logic [3:0] IDX_CONTROL_SETTINGS = 4'h1;
    localparam logic [3:0] IDX_LOWER_ALERT_LIMIT = 4'h2;
    localparam logic [3:0] IDX_UPPER_ALERT_LIMIT = 4'h3;
    localparam logic [3:0] IDX_EVENT_STATUS = 4'h4;
    localparam logic [3:0] IDX_EVENT_ENABLE = 4'h5;
    localparam logic [3:0] IDX_EVENT_CLEAR = 4'h6;
    // ------------------------------------------------------------
    // Control settings field positions
    // ------------------------------------------------------------
    localparam int POS_POWER_DOWN = 0;
    localparam int POS_STYLE = 1;
    localparam int POS_POLARITY = 2;
    localparam int POS_FAULT_DEPTH = 3;
    localparam int POS_ALERT_STATE = 5;
    localparam int POS_WIDE_RANGE = 6;
    localparam int POS_RATE = 7;
    localparam logic [15:0] CTRL_WRITABLE = 16'h01df;
    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [15:0] RST_CONTROL = 16'h0100;
    localparam logic [15:0] RST_LOWER = 16'h4b00;
    localparam logic [15:0] RST_UPPER = 16'h5000;
    // ------------------------------------------------------------
    // Conversion intervals, in ms, and derived cycle counts at 50 MHz
    // ------------------------------------------------------------
    localparam int CLK_HZ = 50_000_000;
    localparam int CONV_MS_0 = 4000;
    localparam int CONV_MS_1 = 1000;
    localparam int CONV_MS_2 = 250;
    localparam int CONV_MS_3 = 125;
    localparam int CONV_CYC_0 = CONV_MS_0 * (CLK_HZ / 1000);
    localparam int CONV_CYC_1 = CONV_MS_1 * (CLK_HZ / 1000);
    localparam int CONV_CYC_2 = CONV_MS_2 * (CLK_HZ / 1000);
    localparam int CONV_CYC_3 = CONV_MS_3 * (CLK_HZ / 1000);
    // Event status bits
    localparam int EVT_ALERT_SET = 0;
    localparam int EVT_ALERT_CLR = 1;
    localparam int EVT_CONV_DONE = 2;
endpackage : tat_pkg

// ==== tat_fault_counter.sv ====
// Consecutive fault counter with selectable queue depth
`timescale 1ns/1ps
`default_nettype none
module tat_fault_counter #(
    parameter int CNT_W = 3
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic sample,
    input wire logic hit,
    input wire logic [1:0] depth_sel,
    output logic reached
);
    logic [CNT_W-1:0] count;
    logic [CNT_W-1:0] need;
    logic [CNT_W-1:0] next_count;
    // Depth choices one, two, four or six
    assign need = (depth_sel == 2'd0) ? CNT_W'(1) : (depth_sel == 2'd1) ? CNT_W'(2) :
                  (depth_sel == 2'd2) ? CNT_W'(4) : CNT_W'(6); // RULE6
    // Saturating count of hits, cleared by a miss
    assign next_count = !hit ? '0 : (count < need) ? count + CNT_W'(1) : count; // RULE13
    assign reached = sample && hit && (next_count >= need);
    // Counter register
    always_ff @(posedge core_clk) begin
        if (rst) begin
            count <= '0;
        end else if (sample) begin
            count <= next_count; // RULE13
        end
    end
endmodule : tat_fault_counter
`default_nettype wire

// ==== tat_core.sv ====
// Temperature alert thermostat with Avalon-MM register slave
// How it works
// RULE1 - Comparator style: alert asserts after enough consecutive over-upper results.
// RULE2 - Comparator style: alert drops after enough consecutive below-lower results.
// RULE3 - Interrupt style: falling below lower limit alone never drops alert.
// RULE4 - Interrupt style: alert clears on register read or entering power-down.
// RULE5 - A result above the upper limit is a fault.
// RULE6 - Fault depth selects one, two, four or six faults; one by default.
// RULE7 - Alert pin is active low unless polarity select makes it active high.
// RULE8 - Alert state bit shows the alert is active.
// RULE9 - Conversion rate select sets the interval between conversions.
// RULE10 - Writes change only writable bits; read-only bits stay device driven.
// RULE11 - In power-down no conversions run; result register holds.
// RULE12 - Normal range uses 12-bit values, wide range 13-bit values.
// RULE13 - Faults counted once per conversion; a miss restarts the count.
`timescale 1ns/1ps
`default_nettype none
module tat_core #(
    parameter int CONV_CYC_0 = tat_pkg::CONV_CYC_0,
    parameter int CONV_CYC_1 = tat_pkg::CONV_CYC_1,
    parameter int CONV_CYC_2 = tat_pkg::CONV_CYC_2,
    parameter int CONV_CYC_3 = tat_pkg::CONV_CYC_3
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    output logic avs_response_err,
    input wire logic [12:0] sensor_value,
    output logic alert_n_pin,
    output logic irq
);
    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [15:0] temperature_result;
    logic [15:0] control_settings;
    logic [15:0] lower_alert_limit;
    logic [15:0] upper_alert_limit;
    logic [2:0] event_status;
    logic [2:0] event_enable;
    logic alert_state_bit;
    logic [31:0] conv_timer;
    logic ack;
    logic [12:0] sens_s1;
    logic [12:0] sens_s2;
    // ------------------------------------------------------------
    // Field decode
    // ------------------------------------------------------------
    wire power_down_select = control_settings[tat_pkg::POS_POWER_DOWN];
    wire thermostat_style_select = control_settings[tat_pkg::POS_STYLE];
    wire alert_polarity_select = control_settings[tat_pkg::POS_POLARITY];
    wire [1:0] fault_depth_select = control_settings[tat_pkg::POS_FAULT_DEPTH +: 2];
    wire wide_range_select = control_settings[tat_pkg::POS_WIDE_RANGE];
    wire [1:0] conversion_rate_select = control_settings[tat_pkg::POS_RATE +: 2];
    // Bus decode: one cycle of waitrequest, answer on the second cycle
    wire req = (avs_read || avs_write) && !ack;
    wire wr_en = avs_write && ack;
    wire rd_en = avs_read && ack;
    wire hit_temp = avs_address == tat_pkg::IDX_TEMPERATURE_RESULT;
    wire hit_ctrl = avs_address == tat_pkg::IDX_CONTROL_SETTINGS;
    wire hit_low = avs_address == tat_pkg::IDX_LOWER_ALERT_LIMIT;
    wire hit_up = avs_address == tat_pkg::IDX_UPPER_ALERT_LIMIT;
    wire hit_sts = avs_address == tat_pkg::IDX_EVENT_STATUS;
    wire hit_en = avs_address == tat_pkg::IDX_EVENT_ENABLE;
    wire hit_clr = avs_address == tat_pkg::IDX_EVENT_CLEAR;
    wire mapped = hit_temp || hit_ctrl || hit_low || hit_up || hit_sts || hit_en || hit_clr;
    wire [15:0] be_mask = {{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
    assign avs_waitrequest = (avs_read || avs_write) && !ack;
    // A read of the result, control or either limit register counts as the host having read the registers
    wire host_read = rd_en && (hit_temp || hit_ctrl || hit_low || hit_up); // RULE4
    // ------------------------------------------------------------
    // Conversion timing
    // ------------------------------------------------------------
    wire [31:0] conv_len = (conversion_rate_select == 2'd0) ? 32'(CONV_CYC_0) :
                           (conversion_rate_select == 2'd1) ? 32'(CONV_CYC_1) :
                           (conversion_rate_select == 2'd2) ? 32'(CONV_CYC_2) :
                           32'(CONV_CYC_3); // RULE9
    wire conv_done = !power_down_select && (conv_timer >= conv_len - 32'h1); // RULE11
    // Result formatting: 12-bit left aligned, or 13-bit with flag in bit 0
    wire [15:0] next_result = wide_range_select ? {sens_s2, 3'b001} :
                              {sens_s2[11:0], 4'h0}; // RULE12
    wire signed [15:0] res_s = $signed(next_result);
    wire over_upper = res_s > $signed(upper_alert_limit); // RULE5
    wire under_lower = res_s < $signed(lower_alert_limit);
    // Fault condition follows the current alert state
    wire hit_cond = alert_state_bit ? under_lower : over_upper;
    wire depth_reached;
    wire entering_pd = wr_en && hit_ctrl && avs_byteenable[0] &&
                       avs_writedata[tat_pkg::POS_POWER_DOWN] && !power_down_select;
    wire int_clear = thermostat_style_select && (host_read || entering_pd); // RULE4
    wire set_alert = !alert_state_bit && depth_reached; // RULE1
    wire clr_alert = alert_state_bit &&
                     ((!thermostat_style_select && depth_reached) || int_clear); // RULE2 RULE3
    wire [2:0] evt = {conv_done, clr_alert, set_alert};
    // Restart the streak when the alert flips, so faults of the old condition never carry over
    wire fault_restart = rst || set_alert || clr_alert; // RULE13
    // Fault queue
    tat_fault_counter #(
        .CNT_W(3)
    ) u_faults (
        .core_clk(core_clk),
        .rst(fault_restart),
        .sample(conv_done),
        .hit(hit_cond),
        .depth_sel(fault_depth_select),
        .reached(depth_reached)
    );
    // Input synchroniser for the sensor value
    always_ff @(posedge core_clk) begin
        sens_s1 <= sensor_value;
        sens_s2 <= sens_s1;
    end
    // Conversion interval timer, cleared and held at zero in power-down
    always_ff @(posedge core_clk) begin
        if (rst || power_down_select || conv_done) begin
            conv_timer <= 32'h0; // RULE11
        end else begin
            conv_timer <= conv_timer + 32'h1;
        end
    end
    // Temperature result, updated only on completed conversions
    always_ff @(posedge core_clk) begin
        if (rst) begin
            temperature_result <= 16'h0;
        end else if (conv_done) begin
            temperature_result <= next_result; // RULE11 RULE12
        end
    end
    // Alert state
    always_ff @(posedge core_clk) begin
        if (rst) begin
            alert_state_bit <= 1'b0;
        end else if (set_alert) begin
            alert_state_bit <= 1'b1; // RULE1 RULE8
        end else if (clr_alert) begin
            alert_state_bit <= 1'b0; // RULE2 RULE4
        end
    end
    // Writable registers, masked by byte enables and writable bits
    always_ff @(posedge core_clk) begin
        if (rst) begin
            control_settings <= tat_pkg::RST_CONTROL;
            lower_alert_limit <= tat_pkg::RST_LOWER;
            upper_alert_limit <= tat_pkg::RST_UPPER;
            event_enable <= 3'h0;
        end else if (wr_en) begin
            if (hit_ctrl) begin
                control_settings <= (control_settings & ~(be_mask & tat_pkg::CTRL_WRITABLE)) |
                    (avs_writedata[15:0] & be_mask & tat_pkg::CTRL_WRITABLE); // RULE10
            end
            if (hit_low) begin
                lower_alert_limit <= (lower_alert_limit & ~be_mask) |
                                     (avs_writedata[15:0] & be_mask);
            end
            if (hit_up) begin
                upper_alert_limit <= (upper_alert_limit & ~be_mask) |
                                     (avs_writedata[15:0] & be_mask);
            end
            if (hit_en && avs_byteenable[0]) begin
                event_enable <= avs_writedata[2:0];
            end
        end
    end
    // Sticky events: a set in the clearing cycle wins
    wire [2:0] clr_bits = (wr_en && hit_clr && avs_byteenable[0]) ? avs_writedata[2:0] : 3'h0;
    always_ff @(posedge core_clk) begin
        if (rst) begin
            event_status <= 3'h0;
        end else begin
            event_status <= (event_status & ~clr_bits) | evt;
        end
    end
    // Read data mux, alert state bit inserted as device-driven value
    wire [15:0] ctrl_view = {control_settings[15:6], alert_state_bit,
                             control_settings[4:0]}; // RULE8 RULE10
    wire [15:0] rd_mux = hit_temp ? temperature_result : hit_ctrl ? ctrl_view :
                         hit_low ? lower_alert_limit : hit_up ? upper_alert_limit :
                         hit_sts ? {13'h0, event_status} : hit_en ? {13'h0, event_enable} :
                         16'h0;
    always_ff @(posedge core_clk) begin
        if (rst) begin
            ack <= 1'b0;
            avs_readdata <= 32'h0;
            avs_response_err <= 1'b0;
        end else begin
            ack <= req;
            avs_readdata <= {16'h0, rd_mux};
            avs_response_err <= req && !mapped;
        end
    end
    // Outputs
    assign alert_n_pin = alert_state_bit ^ ~alert_polarity_select; // RULE7
    assign irq = |(event_status & event_enable);
    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    a_pin_polarity: assert property (@(posedge core_clk) disable iff (rst) // RULE7
        alert_n_pin == (alert_polarity_select ? alert_state_bit : !alert_state_bit))
        else $error("alert pin polarity wrong");
    a_rise_needs_fault: assert property (@(posedge core_clk) disable iff (rst) // RULE1
        $rose(alert_state_bit) |-> $past(conv_done) && $past(over_upper))
        else $error("alert rose without an over-limit conversion");
    a_cmp_fall_cause: assert property (@(posedge core_clk) disable iff (rst) // RULE2
        $fell(alert_state_bit) && !$past(thermostat_style_select) |->
        $past(conv_done) && $past(under_lower))
        else $error("comparator alert fell without a low conversion");
    a_int_fall_cause: assert property (@(posedge core_clk) disable iff (rst) // RULE3
        $fell(alert_state_bit) && $past(thermostat_style_select) |-> $past(int_clear))
        else $error("interrupt alert fell without a clearing event");
    a_int_read_clear: assert property (@(posedge core_clk) disable iff (rst) // RULE4
        thermostat_style_select && alert_state_bit && host_read && !set_alert
        |=> !alert_state_bit)
        else $error("register read did not clear interrupt alert");
    a_pd_holds_temp: assert property (@(posedge core_clk) disable iff (rst) // RULE11
        power_down_select |=> $stable(temperature_result))
        else $error("result changed in power-down");
    a_depth_one: assert property (@(posedge core_clk) disable iff (rst) // RULE6
        conv_done && fault_depth_select == 2'd0 && over_upper && !alert_state_bit
        |=> alert_state_bit)
        else $error("single fault did not raise alert");
    a_ro_temp_write: assert property (@(posedge core_clk) disable iff (rst) // RULE10
        wr_en && hit_temp && !conv_done |=> $stable(temperature_result))
        else $error("write altered read-only result");
    a_wait_one: assert property (@(posedge core_clk) disable iff (rst)
        avs_read && avs_waitrequest |=> !avs_waitrequest)
        else $error("waitrequest held more than one cycle");
    c_alert_set: cover property (@(posedge core_clk) disable iff (rst) set_alert);
    c_cmp_clear: cover property (@(posedge core_clk) disable iff (rst)
        clr_alert && !thermostat_style_select);
    c_int_clear: cover property (@(posedge core_clk) disable iff (rst) clr_alert && int_clear);
    c_irq: cover property (@(posedge core_clk) disable iff (rst) $rose(irq));
endmodule : tat_core
`default_nettype wire

// ==== tat_host_model.sv ====
// Host controller model that masters the Avalon-MM register port
`timescale 1ns/1ps
`default_nettype none
module tat_host_model (
    input wire logic core_clk,
    input wire logic avs_waitrequest,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_response_err,
    output logic [3:0] avs_address,
    output logic avs_read,
    output logic avs_write,
    output logic [31:0] avs_writedata,
    output logic [3:0] avs_byteenable
);
    int hang_count = 0;
    // Idle bus at time zero
    initial begin
        avs_address = 4'h0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h00000000;
        avs_byteenable = 4'h0;
    end
    // One transfer: request held until waitrequest is seen low, then released
    task automatic transfer(input logic wr, input logic [3:0] a, input logic [15:0] wd,
        input logic [3:0] be, output logic [15:0] rd, output logic err);
        int n;
        n = 0;
        @(posedge core_clk);
        avs_address <= a;
        avs_read <= !wr;
        avs_write <= wr;
        avs_writedata <= {16'h0000, wd};
        avs_byteenable <= be;
        // Waitrequest, read data and response are all taken at one rising edge
        @(posedge core_clk);
        while (avs_waitrequest !== 1'b0 && n < 20) begin
            @(posedge core_clk);
            n++;
        end
        if (n >= 20) hang_count++;
        rd = avs_readdata[15:0];
        err = avs_response_err;
        // Released address and write data lines show inverted values so stale data is never trusted
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        avs_address <= ~a;
        avs_writedata <= ~{16'h0000, wd};
    endtask : transfer
endmodule : tat_host_model
`default_nettype wire

// ==== temperature_alert_thermostat_tb.sv ====
// Self-checking bench for the temperature alert block
`timescale 1ns/1ps
`default_nettype none
module temperature_alert_thermostat_tb;
    localparam int CYC [4] = '{20, 10, 8, 5};
    localparam logic [3:0] A_TEMP = tat_pkg::IDX_TEMPERATURE_RESULT;
    localparam logic [3:0] A_CTRL = tat_pkg::IDX_CONTROL_SETTINGS;
    localparam logic [3:0] A_EN = tat_pkg::IDX_EVENT_ENABLE;
    localparam logic [3:0] A_CLR = tat_pkg::IDX_EVENT_CLEAR;
    logic core_clk, rst, rd_e, avs_read, avs_write, avs_waitrequest, avs_response_err;
    logic alert_n_pin, irq;
    logic [12:0] sensor_value;
    logic [15:0] rd_d;
    logic [3:0] avs_address, avs_byteenable;
    logic [31:0] avs_writedata, avs_readdata;
    int bad_count = 0;
    int tests_run = 0;
    // Design and host model
    tat_core #(.CONV_CYC_0(20), .CONV_CYC_1(10), .CONV_CYC_2(8), .CONV_CYC_3(5)) dut_u (
        .core_clk(core_clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .avs_response_err(avs_response_err), .sensor_value(sensor_value),
        .alert_n_pin(alert_n_pin), .irq(irq));
    tat_host_model host_u (
        .core_clk(core_clk), .avs_waitrequest(avs_waitrequest), .avs_readdata(avs_readdata),
        .avs_response_err(avs_response_err), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable));
    // 50 MHz clock
    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end
    // ------------------------------------------------------------
    // Bus, compare and wait helpers
    // ------------------------------------------------------------
    task automatic reg_wr(input logic [3:0] a, input logic [15:0] d, input logic [3:0] be = 4'hf);
        logic [15:0] x;
        logic e;
        host_u.transfer(1'b1, a, d, be, x, e);
        if (host_u.hang_count != 0) complete_run();
    endtask : reg_wr
    task automatic reg_rd(input logic [3:0] a);
        host_u.transfer(1'b0, a, 16'h0000, 4'hf, rd_d, rd_e);
        if (host_u.hang_count != 0) complete_run();
    endtask : reg_rd
    task automatic check16(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %0t value %h expected %h", $time, got, exp);
        end
    endtask : check16
    task automatic check1(input logic got, input logic exp);
        check16({15'h0000, got}, {15'h0000, exp});
    endtask : check1
    task automatic wait_out(input logic sel, input logic exp, input int max);
        int n;
        n = 0;
        @(negedge core_clk);
        while (((sel ? irq : alert_n_pin) !== exp) && n < max) begin
            @(negedge core_clk);
            n++;
        end
        check1(sel ? irq : alert_n_pin, exp);
        if ((sel ? irq : alert_n_pin) !== exp) complete_run();
    endtask : wait_out
    task automatic complete_run();
        bad_count += host_u.hang_count;
        $display("bad_count=%0d tests_run=%0d", bad_count, tests_run);
        if (bad_count == 0 && tests_run > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : complete_run
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic scn_reset();
        check1(alert_n_pin, 1'b1);
        reg_rd(A_CTRL);
        check16(rd_d, tat_pkg::RST_CONTROL);
        reg_rd(tat_pkg::IDX_LOWER_ALERT_LIMIT);
        check16(rd_d, tat_pkg::RST_LOWER);
        reg_rd(tat_pkg::IDX_UPPER_ALERT_LIMIT);
        check16(rd_d, tat_pkg::RST_UPPER);
        reg_rd(4'h7);
        check16({rd_d[14:0], rd_e}, 16'h0001);
    endtask : scn_reset
    task automatic scn_format();
        sensor_value <= 13'h0123;
        repeat (30) @(posedge core_clk);
        reg_wr(A_TEMP, 16'hffff);
        reg_rd(A_TEMP);
        check16(rd_d, 16'h1230);
        reg_wr(A_CTRL, 16'h0140);
        repeat (30) @(posedge core_clk);
        reg_rd(A_TEMP);
        check16(rd_d, 16'h0919);
        reg_wr(A_CTRL, 16'h0100);
    endtask : scn_format
    // Every depth: no alert before the count is met (depths above one), then set and clear
    task automatic scn_depth();
        int n;
        for (int k = 0; k < 4; k++) begin
            n = (k == 0) ? 1 : 2 * k;
            reg_wr(A_CTRL, 16'h0100 | (16'(k) << 3));
            sensor_value <= 13'h0600;
            if (n > 1) repeat (8 * n - 10) @(posedge core_clk);
            if (n > 1) check1(alert_n_pin, 1'b1);
            wait_out(1'b0, 1'b0, 8 * n + 20);
            reg_rd(A_CTRL);
            check1(rd_d[tat_pkg::POS_ALERT_STATE], 1'b1);
            sensor_value <= 13'h0400;
            wait_out(1'b0, 1'b1, 8 * n + 20);
        end
    endtask : scn_depth
    // Short hot bursts broken by misses never reach a depth of four
    task automatic scn_streak();
        reg_wr(A_CTRL, 16'h0110);
        repeat (6) begin
            sensor_value <= 13'h0600;
            repeat (12) @(posedge core_clk);
            sensor_value <= 13'h04c0;
            repeat (12) @(posedge core_clk);
            check1(alert_n_pin, 1'b1);
        end
    endtask : scn_streak
    task automatic scn_interrupt();
        sensor_value <= 13'h0400;
        reg_wr(A_CTRL, 16'h0106);
        wait_out(1'b0, 1'b0, 30);
        sensor_value <= 13'h0600;
        wait_out(1'b0, 1'b1, 40);
        sensor_value <= 13'h0400;
        repeat (40) @(posedge core_clk);
        check1(alert_n_pin, 1'b1);
        reg_rd(tat_pkg::IDX_UPPER_ALERT_LIMIT);
        wait_out(1'b0, 1'b0, 4);
        sensor_value <= 13'h0600;
        wait_out(1'b0, 1'b1, 40);
        reg_wr(A_CTRL, 16'h0107);
        wait_out(1'b0, 1'b0, 4);
        sensor_value <= 13'h0100;
        repeat (40) @(posedge core_clk);
        reg_rd(A_TEMP);
        check16(rd_d, 16'h6000);
        sensor_value <= 13'h0400;
        reg_wr(A_CTRL, 16'h0100);
    endtask : scn_interrupt
    task automatic scn_events();
        reg_wr(A_CLR, 16'h0007);
        reg_wr(A_EN, 16'h0001);
        sensor_value <= 13'h0600;
        wait_out(1'b1, 1'b1, 40);
        reg_wr(A_CLR, 16'h0001);
        wait_out(1'b1, 1'b0, 2);
        sensor_value <= 13'h0400;
        repeat (40) @(posedge core_clk);
        check1(irq, 1'b0);
        reg_rd(tat_pkg::IDX_EVENT_STATUS);
        check16(rd_d & 16'h0003, 16'h0002);
        reg_wr(A_EN, 16'h0002);
        wait_out(1'b1, 1'b1, 2);
        reg_wr(A_CLR, 16'h0002);
        wait_out(1'b1, 1'b0, 2);
    endtask : scn_events
    // Interval between two conversion-done events at every rate
    task automatic scn_rate();
        int n;
        reg_wr(A_EN, 16'h0004);
        for (int r = 0; r < 4; r++) begin
            reg_wr(A_CTRL, 16'(r) << 7);
            reg_wr(A_CLR, 16'h0004);
            wait_out(1'b1, 1'b1, 40);
            reg_wr(A_CLR, 16'h0004);
            n = 0;
            // Let the clearing write settle before watching for the next event
            @(negedge core_clk);
            while (irq !== 1'b1 && n < 40) begin
                @(negedge core_clk);
                n++;
            end
            if (n >= 40) complete_run();
            check1(n >= CYC[r] - 4 && n <= CYC[r], 1'b1);
        end
    endtask : scn_rate
    task automatic scn_lanes();
        reg_wr(A_CTRL, 16'hffff, 4'h1);
        reg_rd(A_CTRL);
        check16(rd_d, 16'h01df);
        reg_wr(A_CTRL, 16'hfe00);
        reg_rd(A_CTRL);
        check16(rd_d, 16'h0000);
    endtask : scn_lanes
    // Main sequence
    initial begin
        rst = 1'b1;
        sensor_value = 13'h0400;
        repeat (3) @(posedge core_clk);
        rst <= 1'b0;
        scn_reset();
        scn_format();
        scn_depth();
        scn_streak();
        scn_interrupt();
        scn_events();
        scn_rate();
        scn_lanes();
        complete_run();
    end
endmodule : temperature_alert_thermostat_tb
`default_nettype wire
